// [gie_map.vh]
// Constants for the grouped interrupt expander and its external edge channels.
`ifndef GIE_MAP_VH
`define GIE_MAP_VH
`define GIE_NUM_REQ       96
`define GIE_NUM_USED      54
`define GIE_GROUP_SIZE    8
`define GIE_NUM_LINES     12
`define GIE_VEC_W         22
`define GIE_VEC_AW        7
`define GIE_FETCH_CYCLES  8
`define GIE_NUM_XCH       3
`define GIE_XCNT_W        16
`define GIE_PIN_SEL_W     5
`define GIE_EDGE_FALL     2'h0
`define GIE_EDGE_RISE     2'h1
`define GIE_EDGE_BOTH     2'h2
`define GIE_VEC_RST       22'h000000
`endif

// [gie_vec_ram.v]
// Vector memory with one write port and a registered read port.
`timescale 1ns/1ps
module gie_vec_ram #(
  parameter DW    = 22,
  parameter AW    = 7,
  parameter DEPTH = 96
) (
  mclk,
  wr_en,
  wr_addr,
  wr_data,
  rd_addr,
  rd_data
);
  input  wire          mclk;     // System clock.
  input  wire          wr_en;    // Software write strobe.
  input  wire [AW-1:0] wr_addr;  // Entry written.
  input  wire [DW-1:0] wr_data;  // Vector written.
  input  wire [AW-1:0] rd_addr;  // Entry read.
  output reg  [DW-1:0] rd_data;  // Registered read data.

  reg [DW-1:0] mem [0:DEPTH-1];  // Vector storage, contents undefined until written.

  // Writes land at once; reads return one cycle later.
  always @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// [gie_top.v]
// Grouped interrupt expander with three external edge channels and time-stamp counters.
`timescale 1ns/1ps
`include "gie_map.vh"
module gie_top #(
  parameter NREQ  = `GIE_NUM_REQ,
  parameter NLINE = `GIE_NUM_LINES,
  parameter GSZ   = `GIE_GROUP_SIZE,
  parameter VW    = `GIE_VEC_W,
  parameter AW    = `GIE_VEC_AW,
  parameter NX    = `GIE_NUM_XCH,
  parameter CW    = `GIE_XCNT_W
) (
  mclk,
  sys_rst,
  periph_req,
  req_connected,
  req_enable,
  vec_wr_en,
  vec_wr_addr,
  vec_wr_data,
  xch_enable,
  xch_edge_sel,
  xch_pin_sel,
  gpio_in,
  cpu_ack,
  cpu_ack_line,
  cpu_irq,
  vec_valid,
  vec_data,
  vec_index,
  pending,
  xch_count
);
  input  wire                mclk;           // System clock, 100 MHz.
  input  wire                sys_rst;        // Asynchronous reset, active high.
  input  wire [NREQ-1:0]     periph_req;     // Peripheral request pulses, one cycle each.
  input  wire [NREQ-1:0]     req_connected;  // Positions wired to a peripheral.
  input  wire [NREQ-1:0]     req_enable;     // Per-position software enables.
  input  wire                vec_wr_en;      // Vector memory write strobe.
  input  wire [AW-1:0]       vec_wr_addr;    // Vector entry index.
  input  wire [VW-1:0]       vec_wr_data;    // Vector value.
  input  wire [NX-1:0]       xch_enable;     // External channel enables.
  input  wire [2*NX-1:0]     xch_edge_sel;   // Two bits per channel: edge polarity.
  input  wire [5*NX-1:0]     xch_pin_sel;    // Five bits per channel: pin index.
  input  wire [31:0]         gpio_in;        // Lowest thirty-two general-purpose pins.
  input  wire                cpu_ack;        // CPU starts servicing a line, one-cycle pulse.
  input  wire [3:0]          cpu_ack_line;   // Serviced line, zero-based (0 is the first line).
  output wire [NLINE-1:0]    cpu_irq;        // Combined request per CPU line.
  output reg                 vec_valid;      // Vector on vec_data is valid, one-cycle pulse.
  output wire [VW-1:0]       vec_data;       // Fetched vector, from the memory register.
  output reg  [AW-1:0]       vec_index;      // Request index of the fetched vector.
  output wire [NREQ-1:0]     pending;        // Pending flags, registered.
  output wire [CW*NX-1:0]    xch_count;      // Time-stamp counters, registered.

  localparam ST_IDLE  = 2'h0;  // Waiting for an acknowledge.
  localparam ST_READ  = 2'h1;  // Memory read in flight.
  localparam ST_SAVE  = 2'h2;  // Holding the vector while state is saved.

  reg  [NREQ-1:0]  pend_r;        // Pending flags.
  reg  [NREQ-1:0]  pend_nxt;      // Next pending flags.
  reg  [1:0]       st_r;          // Fetch sequencer state.
  reg  [3:0]       cyc_r;         // Cycles elapsed in the fetch.
  reg  [AW-1:0]    sel_r;         // Index chosen at acknowledge.
  reg  [AW-1:0]    win_idx;       // Lowest pending enabled index in the acked group.
  reg              win_ok;        // A request is present in the acked group.
  reg  [31:0]      win_sum;       // Full-width index sum, trimmed to the index width on purpose.
  wire [NREQ-1:0]  live_req;      // Requests including external channel events.
  wire [NX-1:0]    xedge;         // Qualified edge per channel.
  wire [NREQ-1:0]  act;           // Pending and enabled.
  integer          i;

  // A pending flag reaches its CPU line only while its enable is set.
  assign act = pend_r & req_enable;

  // Each group of eight ORs onto one CPU line.
  genvar g;
  generate
    for (g = 0; g < NLINE; g = g + 1) begin : grp
      assign cpu_irq[g] = |act[g*GSZ +: GSZ];
    end
  endgenerate

  // External channels: pick a pin, detect the chosen edge, and stamp.
  genvar x;
  generate
    for (x = 0; x < NX; x = x + 1) begin : xch
      reg            prev_r;   // Pin level seen on the previous edge.
      reg            armed_r;  // Low in the first cycle after reset, so no false edge follows it.
      reg  [CW-1:0]  cnt_r;    // Time-stamp counter of this channel.
      wire [4:0]     psel = xch_pin_sel[5*x +: 5];
      wire           lvl  = gpio_in[psel];
      wire [1:0]     es   = xch_edge_sel[2*x +: 2];
      wire           rise = armed_r & lvl & ~prev_r;
      wire           fall = armed_r & ~lvl & prev_r;
      // A disabled channel sees no edge at all.
      assign xedge[x] = xch_enable[x] &
                        ((es == `GIE_EDGE_FALL) ? fall :
                         (es == `GIE_EDGE_RISE) ? rise :
                         (es == `GIE_EDGE_BOTH) ? (rise | fall) : 1'b0);
      assign xch_count[CW*x +: CW] = cnt_r;
      // Counter runs freely and restarts on a qualified edge.
      // The first sample after reset only primes the stored level, whatever level the pin idles at.
      always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          prev_r  <= 1'b0;
          armed_r <= 1'b0;
          cnt_r   <= {CW{1'b0}};
        end else begin
          prev_r  <= lvl;
          armed_r <= 1'b1;
          if (xedge[x]) begin
            cnt_r <= {CW{1'b0}};
          end else begin
            cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
          end
        end
      end
    end
  endgenerate

  // External events enter the last positions of the first group.
  assign live_req = (periph_req & req_connected) |
                    ({{(NREQ-NX){1'b0}}, xedge} << (GSZ - NX));

  // Fixed ordering: lowest enabled pending position in the acknowledged group.
  always @* begin
    win_idx = {AW{1'b0}};
    win_ok  = 1'b0;
    win_sum = 32'h00000000;
    for (i = GSZ - 1; i >= 0; i = i - 1) begin
      // Lines past the last group have no flags; never index beyond them.
      if (cpu_ack_line < NLINE && act[cpu_ack_line*GSZ + i]) begin
        win_sum = cpu_ack_line * GSZ + i;
        win_idx = win_sum[AW-1:0];
        win_ok  = 1'b1;
      end
    end
  end

  // New requests set flags; set wins over the fetch clear.
  always @* begin
    pend_nxt = pend_r;
    if (cpu_ack && win_ok && st_r == ST_IDLE && cpu_ack_line < NLINE) begin
      pend_nxt[win_idx] = 1'b0;
    end
    pend_nxt = pend_nxt | live_req;
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_r <= {NREQ{1'b0}};
    end else begin
      pend_r <= pend_nxt;
    end
  end

  assign pending = pend_r;

  // Fetch sequencer: read the vector and hold the CPU for the save window.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r      <= ST_IDLE;
      cyc_r     <= 4'h0;
      sel_r     <= {AW{1'b0}};
      vec_valid <= 1'b0;
      vec_index <= {AW{1'b0}};
    end else begin
      vec_valid <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (cpu_ack && win_ok && cpu_ack_line < NLINE) begin
            sel_r <= win_idx;
            cyc_r <= 4'h1;
            st_r  <= ST_READ;
          end
        end
        ST_READ: begin
          // Memory data appears next cycle.
          vec_valid <= 1'b1;
          vec_index <= sel_r;
          cyc_r     <= cyc_r + 4'h1;
          st_r      <= ST_SAVE;
        end
        ST_SAVE: begin
          // Remaining cycles cover saving of CPU state.
          if (cyc_r == `GIE_FETCH_CYCLES - 1) begin
            st_r <= ST_IDLE;
          end
          cyc_r <= cyc_r + 4'h1;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Per-request vector store, writable at any time.
  gie_vec_ram #(
    .DW    (VW),
    .AW    (AW),
    .DEPTH (NREQ)
  ) u_vec (
    .mclk    (mclk),
    .wr_en   (vec_wr_en),
    .wr_addr (vec_wr_addr),
    .wr_data (vec_wr_data),
    .rd_addr (sel_r),
    .rd_data (vec_data)
  );
endmodule

// [gie_top_properties.sv]
// Concurrent checks on the ports of the grouped interrupt expander.
`timescale 1ns/1ps
module gie_top_properties (
  input logic        mclk,
  input logic        sys_rst,
  input logic [95:0] periph_req,
  input logic [95:0] req_connected,
  input logic [95:0] req_enable,
  input logic [2:0]  xch_enable,
  input logic        cpu_ack,
  input logic [3:0]  cpu_ack_line,
  input logic [11:0] cpu_irq,
  input logic        vec_valid,
  input logic [6:0]  vec_index,
  input logic [95:0] pending,
  input logic [47:0] xch_count
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [11:0] grp_irq; // Expected level of each CPU line.
  // Each line is the OR of the enabled pending flags of its group of eight.
  always_comb for (int g = 0; g < 12; g++) grp_irq[g] = |(pending[g*8+:8] & req_enable[g*8+:8]);
  a_line_or: assert property (cpu_irq == grp_irq) else $error("line level wrong");
  a_req_sets: assert property (##1 (pending & $past(periph_req & req_connected)) == $past(periph_req & req_connected))
    else $error("request not latched");
  a_unused_quiet: assert property ((pending & ~req_connected) == 96'h0) else $error("unwired pending");
  a_vec_lat: assert property (vec_valid |-> $past(cpu_ack, 2)) else $error("vector latency wrong");
  a_vec_space: assert property (vec_valid |=> !vec_valid [*7]) else $error("vectors too close");
  a_vec_line: assert property (vec_valid |-> vec_index[6:3] == $past(cpu_ack_line, 2)) else $error("wrong group");
  a_fetch_clear: assert property (vec_valid |-> !pending[vec_index]) else $error("pending kept");
  a_xcnt_run: assert property (##1 (xch_count[15:0] == 16'h0000 || xch_count[15:0] == $past(xch_count[15:0]) + 16'h0001))
    else $error("counter not running");
  a_xch_off: assert property (!$past(xch_enable[0]) && !$past(periph_req[5]) |-> !$rose(pending[5]))
    else $error("disabled channel fired");
  // Main scenarios reached.
  cover property (vec_valid && vec_index == 7'h5F);
  cover property (pending[16] && !cpu_irq[2]);
  cover property (pending[7] && xch_count[47:32] == 16'h0000);
endmodule
bind gie_top gie_top_properties gie_top_properties_inst (.mclk, .sys_rst, .periph_req, .req_connected, .req_enable,
  .xch_enable, .cpu_ack, .cpu_ack_line, .cpu_irq, .vec_valid, .vec_index, .pending, .xch_count);

// [gie_cpu_model.sv]
// Core model that acknowledges CPU lines and paces vector fetches.
`timescale 1ns/1ps
module gie_cpu_model (
  input  logic        mclk,
  input  logic        sys_rst,
  input  logic        go,
  input  logic [11:0] cpu_irq,
  output logic        cpu_ack,
  output logic [3:0]  cpu_ack_line
);
  logic [3:0] gap_r; // Cycles left before the next acknowledge.
  // Acknowledge the lowest active line, then wait out the fetch window.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_ack <= 1'b0;
      cpu_ack_line <= 4'h0;
      gap_r <= 4'h0;
    end else begin
      cpu_ack <= 1'b0;
      cpu_ack_line <= ~cpu_ack_line;
      if (gap_r != 4'h0) begin
        gap_r <= gap_r - 4'h1;
      end else if (go && cpu_irq != 12'h000) begin
        cpu_ack <= 1'b1;
        gap_r <= 4'h7;
        for (int i = 11; i >= 0; i--) if (cpu_irq[i]) cpu_ack_line <= i[3:0];
      end
    end
  end
endmodule

// [gie_top_tb.sv]
// Testbench of the grouped interrupt expander.
`timescale 1ns/1ps
module gie_top_tb;
  logic        mclk = 1'b0, sys_rst = 1'b1, vec_wr_en = 1'b0, go = 1'b0, cpu_ack, vec_valid;
  logic [95:0] periph_req = 96'h0, pending;
  logic [95:0] req_connected = {1'b1, 42'h0, 53'h1FFFFFFFFFFFFF}; // Fifty-four wired positions.
  logic [95:0] req_enable = {1'b1, 42'h0, 53'h1FFFFFFFFEFF1F}; // Positions 5, 6, 7 and 16 off.
  logic [6:0]  vec_wr_addr = 7'h00, vec_index;
  logic [21:0] vec_wr_data = 22'h000000, vec_data;
  logic [2:0]  xch_enable = 3'h0;
  logic [5:0]  xch_edge_sel = 6'h3F;
  logic [14:0] xch_pin_sel = {5'h1F, 5'h10, 5'h01}; // Pins 1, 16 and 31.
  logic [31:0] gpio_in = 32'h0;
  logic [3:0]  cpu_ack_line;
  logic [11:0] cpu_irq;
  logic [47:0] xch_count;
  int          fails = 0, n_checks = 0, cyc = 0;
  // Free-running clock and hang guard.
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 1000) begin
      fails++;
      give_verdict;
    end
  end
  gie_top gie_top_inst (.mclk, .sys_rst, .periph_req, .req_connected, .req_enable, .vec_wr_en, .vec_wr_addr,
    .vec_wr_data, .xch_enable, .xch_edge_sel, .xch_pin_sel, .gpio_in, .cpu_ack, .cpu_ack_line, .cpu_irq,
    .vec_valid, .vec_data, .vec_index, .pending, .xch_count);
  gie_cpu_model gie_cpu_model_inst (.mclk, .sys_rst, .go, .cpu_irq, .cpu_ack, .cpu_ack_line);
  task check(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task wr(input logic [6:0] a, input logic [21:0] d);
    @(posedge mclk) {vec_wr_en, vec_wr_addr, vec_wr_data} <= {1'b1, a, d};
    @(posedge mclk) vec_wr_en <= 1'b0;
  endtask
  // Waits for the acknowledge, then judges the vector two cycles on.
  task automatic fetch(input int idx, input logic [21:0] v);
    int n = 0;
    #1;
    while (cpu_ack !== 1'b1 && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check(n < 40, 1);
    repeat (2) @(posedge mclk);
    #1;
    check(vec_valid, 1);
    check(vec_index, idx);
    check(vec_data, v);
    check(pending[idx], 0);
  endtask
  task edge_to(input int p, input logic v);
    @(posedge mclk) gpio_in[p] <= v;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task t_vec;
    wr(7'h09, 22'h2AAAA9);
    wr(7'h0C, 22'h15555C);
    wr(7'h5F, 22'h3C005F);
    wr(7'h10, 22'h0F0F10);
    @(posedge mclk) periph_req <= 96'h800000000000000000001200;
    @(posedge mclk) periph_req <= 96'h0;
    go <= 1'b1;
    fetch(9, 22'h2AAAA9);
    fetch(12, 22'h15555C);
    fetch(95, 22'h3C005F);
    $display("vector test done");
  endtask
  task t_en;
    @(posedge mclk) periph_req <= 96'h1000000000010000;
    @(posedge mclk) periph_req <= 96'h0;
    repeat (2) @(posedge mclk);
    #1;
    check(pending[16], 1);
    check(cpu_irq[2], 0);
    check(pending[60], 0);
    @(posedge mclk) req_enable[16] <= 1'b1;
    fetch(16, 22'h0F0F10);
    $display("enable test done");
  endtask
  // Channel a falls, b rises, c takes both edges.
  task automatic t_xch;
    for (int ch = 0; ch < 3; ch++) begin
      @(posedge mclk) xch_edge_sel[2*ch+:2] <= 2'(ch);
      edge_to(ch * 15 + 1, 1'b1);
      edge_to(ch * 15 + 1, 1'b0);
      check(pending[5+ch], 0);
      @(posedge mclk) xch_enable[ch] <= 1'b1;
      edge_to(ch * 15 + 1, 1'b1);
      check(pending[5+ch], ch != 0);
      edge_to(ch * 15 + 1, 1'b0);
      check(pending[5+ch], 1);
      check(xch_count[16*ch+:16] < 16'h0004, ch != 1);
    end
    // Code 3 turns channel a off, so its counter must keep running.
    @(posedge mclk) xch_edge_sel[1:0] <= 2'h3;
    edge_to(1, 1'b1);
    check(xch_count[15:0] < 16'h0004, 0);
    $display("external test done");
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    t_vec;
    t_en;
    t_xch;
    give_verdict;
  end
endmodule
